// ### verilog/amis_top.sv
// converter mode, input select, start bit and results behind ahb-lite
// Notes on behaviour
// - mode bits 4..3 pick one-shot, repeat, single sweep or repeat sweep.
// - clock bits 2..0 pick the conversion clock, 011 is undivided.
// - trigger bits 7..6 disable (00), use the timer (10) or pin (11).
// - group bits 7..6 choose inputs 0/1, 2/3, 4/7 or 5/6.
// - single modes convert the picked input, sweep modes convert both.
// - first input result goes to result 0, second to result 1, 10 bits.
// - the run bit self-clears after a one-shot or single sweep round, set by any start.
//
// Local design decision: the AHB-Lite slave port.
`include "amis_defs.svh"
module amis_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // conversion engine
  input wire logic res_valid,
  input wire logic res_second,
  input wire logic [`AMIS_RES_W-1:0] res_data,
  input wire logic round_done,
  // start sources
  input wire logic timer_trig,
  input wire logic external_trigger_pin_n,
  // configuration towards the engine
  output logic conv_clk_en,
  output amis_pkg::amis_opmode_t op_mode,
  output amis_pkg::amis_trig_t trig_sel,
  output logic [2:0] first_input,
  output logic [2:0] second_input,
  output logic [2:0] active_input,
  output logic sweep_en,
  output logic conversion_run_bit
);
  import amis_pkg::*;
  logic [7:0] mode_r;
  logic [7:0] insel_r;
  logic run_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [11:0] addr_r;
  logic ext_prev_r;
  logic [2:0] div_cnt_r;
  logic [`AMIS_RES_W-1:0] res_r [2];
  logic [31:0] rd_word;
  logic run_nxt;
  logic [2:0] map_first;
  logic [2:0] map_second;
  logic [2:0] map_active;
  logic map_sweep;

  // address phase capture and decode
  wire logic take = hsel && htrans[1] && hready;
  wire logic sel_mode = addr_r == `AMIS_ADDR(`AMIS_IDX_MODE);
  wire logic sel_insel = addr_r == `AMIS_ADDR(`AMIS_IDX_INSEL);
  wire logic sel_run = addr_r == `AMIS_ADDR(`AMIS_IDX_RUN);
  wire logic sel_res0 = addr_r == `AMIS_ADDR(`AMIS_IDX_RES0);
  wire logic sel_res1 = addr_r == `AMIS_ADDR(`AMIS_IDX_RES1);
  wire logic wr_mode = wr_pend_r && sel_mode;
  wire logic wr_insel = wr_pend_r && sel_insel;
  wire logic wr_run = wr_pend_r && sel_run;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end
    else
    begin
      wr_pend_r <= take && hwrite && (hsize == `AMIS_HSIZE_WORD);
      rd_pend_r <= take && !hwrite;
      if (take)
        addr_r <= haddr[11:0];
    end
  end

  // read mux; unmapped addresses read zero
  assign rd_word = sel_mode ? {24'h000000, mode_r}
    : sel_insel ? {24'h000000, insel_r}
    : sel_run ? {31'h00000000, run_r}
    : sel_res0 ? {22'h000000, res_r[0]}
    : sel_res1 ? {22'h000000, res_r[1]}
    : 32'h00000000;

  // reads take one wait state so a write just before is seen
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hrdata <= rd_pend_r ? rd_word : 32'h00000000;
      hreadyout <= !(take && !hwrite);
      hresp <= 1'b0;
    end
  end

  // configuration registers, reserved bits stored as written
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mode_r <= `AMIS_RESET_BYTE;
      insel_r <= `AMIS_RESET_BYTE;
    end
    else
    begin
      if (wr_mode)
        mode_r <= hwdata[7:0];
      if (wr_insel)
        insel_r <= hwdata[7:0];
    end
  end

  // start sources and self-clearing run bit, a set beats a clear
  wire logic [1:0] trig_code = mode_r[`AMIS_TRIG_MSB:`AMIS_TRIG_LSB];
  wire logic [1:0] md_code = mode_r[`AMIS_MD_MSB:`AMIS_MD_LSB];
  wire logic ext_fall = ext_prev_r && !external_trigger_pin_n;
  wire logic hw_start = ((trig_code == trig_timer) && timer_trig)
    || ((trig_code == trig_ext) && ext_fall);
  wire logic sw_set = wr_run && hwdata[`AMIS_RUN_BIT];
  wire logic sw_clr = wr_run && !hwdata[`AMIS_RUN_BIT];
  wire logic single_round = (md_code == op_one_shot)
    || (md_code == op_single_sweep);
  wire logic auto_clr = round_done && single_round;
  assign run_nxt = (sw_set || hw_start) ? 1'b1
    : (sw_clr || auto_clr) ? 1'b0 : run_r;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      run_r <= 1'b0;
      ext_prev_r <= 1'b1;
    end
    else
    begin
      run_r <= run_nxt;
      ext_prev_r <= external_trigger_pin_n;
    end
  end

  // result storage, one register per input of the group
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_res
      always_ff @(posedge mclk)
      begin
        if (rst)
          res_r[gi] <= `AMIS_RES_W'(0);
        else if (res_valid && (res_second == 1'(gi)))
          res_r[gi] <= res_data;
      end
    end
  endgenerate

  // conversion clock divider; forbidden codes give no enable
  wire logic [2:0] cks_code = mode_r[`AMIS_CKS_MSB:`AMIS_CKS_LSB];
  wire logic cks_legal = cks_code <= `AMIS_CKS_MAX;
  wire logic [2:0] div_last = (cks_code == cks_code0) ? `AMIS_DIV_LAST_C0
    : (cks_code == cks_code1) ? `AMIS_DIV_LAST_C1
    : (cks_code == cks_code2) ? `AMIS_DIV_LAST_C2
    : (cks_code == cks_undivided) ? `AMIS_DIV_LAST_F1
    : `AMIS_DIV_LAST_C4;
  wire logic div_hit = div_cnt_r >= div_last;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      div_cnt_r <= 3'h0;
      conv_clk_en <= 1'b0;
    end
    else
    begin
      div_cnt_r <= (!cks_legal || div_hit) ? 3'h0 : div_cnt_r + 3'h1;
      conv_clk_en <= cks_legal && div_hit;
    end
  end

  // channel mapping
  amis_chan_map u_map (
    .group_sel(insel_r[`AMIS_GRP_MSB:`AMIS_GRP_LSB]),
    .channel_pick(insel_r[`AMIS_PICK_BIT]),
    .op_mode(amis_opmode_t'(md_code)),
    .first_input(map_first),
    .second_input(map_second),
    .active_input(map_active),
    .sweep_en(map_sweep)
  );

  // registered configuration outputs
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      op_mode <= op_one_shot;
      trig_sel <= trig_none;
      first_input <= 3'h0;
      second_input <= 3'h0;
      active_input <= 3'h0;
      sweep_en <= 1'b0;
    end
    else
    begin
      op_mode <= amis_opmode_t'(md_code);
      trig_sel <= amis_trig_t'(trig_code);
      first_input <= map_first;
      second_input <= map_second;
      active_input <= map_active;
      sweep_en <= map_sweep;
    end
  end
  assign conversion_run_bit = run_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence mode_write_s;
    wr_mode ##1 !wr_mode;
  endsequence
  sequence hold_single_s;
    run_r && round_done && single_round && !sw_set && !hw_start;
  endsequence

  mode_field_out_a: assert property (mode_write_s |=>
    op_mode == $past(hwdata[`AMIS_MD_MSB:`AMIS_MD_LSB], 2))
    else $error("operating mode output does not follow the write");
  undivided_clock_a: assert property (
    (cks_code == cks_undivided)[*2] |=> conv_clk_en)
    else $error("undivided clock code did not enable every cycle");
  forbidden_clock_a: assert property (!cks_legal |=> !conv_clk_en)
    else $error("forbidden clock code produced an enable");
  timer_start_a: assert property (
    trig_code == trig_timer && timer_trig |=> conversion_run_bit)
    else $error("timer trigger did not start conversion");
  pin_start_a: assert property (
    trig_code == trig_ext && $fell(external_trigger_pin_n) |=> run_r)
    else $error("external trigger did not start conversion");
  no_hw_start_a: assert property (
    trig_code == trig_none && !run_r && !sw_set |=> !run_r)
    else $error("conversion started with hardware start disabled");
  group_two_a: assert property (
    insel_r[`AMIS_GRP_MSB:`AMIS_GRP_LSB] == 2'h2 |=>
    first_input == 3'h4 && second_input == 3'h7)
    else $error("group two does not map to inputs four and seven");
  single_pick_a: assert property (
    !mode_r[`AMIS_MD_MSB] && insel_r[`AMIS_PICK_BIT]
    |=> active_input == second_input && !sweep_en)
    else $error("single mode did not pick the second input");
  result_store_a: assert property (res_valid && res_second |=>
    res_r[1] == $past(res_data) ##1 1'b1)
    else $error("second input result not stored in result one");
  round_clear_a: assert property (hold_single_s |=> !run_r ##2 1'b1)
    else $error("run bit did not clear after a single round");
endmodule

// ### verilog/amis_defs.svh
// register indices, field positions and divider counts for the mode block
`ifndef AMIS_DEFS_SVH
`define AMIS_DEFS_SVH
// register indices; the byte address is four times the index
`define AMIS_IDX_RES0 8'h98
`define AMIS_IDX_RES1 8'h9A
`define AMIS_IDX_MODE 8'h9C
`define AMIS_IDX_INSEL 8'h9D
`define AMIS_IDX_RUN 8'h9E
`define AMIS_ADDR(idx) (12'(idx) << 2)
// reset value of every control register
`define AMIS_RESET_BYTE 8'h00
// mode register fields
`define AMIS_CKS_MSB 2
`define AMIS_CKS_LSB 0
`define AMIS_MD_MSB 4
`define AMIS_MD_LSB 3
`define AMIS_TRIG_MSB 7
`define AMIS_TRIG_LSB 6
// input select fields
`define AMIS_GRP_MSB 7
`define AMIS_GRP_LSB 6
`define AMIS_PICK_BIT 0
// run register field
`define AMIS_RUN_BIT 0
// result width
`define AMIS_RES_W 10
// last count of the conversion clock divider per select code
`define AMIS_DIV_LAST_C0 3'h7
`define AMIS_DIV_LAST_C1 3'h3
`define AMIS_DIV_LAST_C2 3'h1
`define AMIS_DIV_LAST_F1 3'h0
`define AMIS_DIV_LAST_C4 3'h7
`define AMIS_CKS_MAX 3'h4
// first and second input of groups 3..0, packed three bits each
`define AMIS_GRP_FIRST {3'h5, 3'h4, 3'h2, 3'h0}
`define AMIS_GRP_SECOND {3'h6, 3'h7, 3'h3, 3'h1}
// ahb-lite word transfer size
`define AMIS_HSIZE_WORD 3'h2
`endif

// ### verilog/amis_pkg.sv
// types of the converter mode and input select block
package amis_pkg;
  typedef enum logic [1:0] {
    op_one_shot = 2'b00,
    op_repeat = 2'b01,
    op_single_sweep = 2'b10,
    op_repeat_sweep = 2'b11
  } amis_opmode_t;
  typedef enum logic [1:0] {
    trig_none = 2'b00,
    trig_forbidden = 2'b01,
    trig_timer = 2'b10,
    trig_ext = 2'b11
  } amis_trig_t;
  typedef enum logic [2:0] {
    cks_code0 = 3'b000,
    cks_code1 = 3'b001,
    cks_code2 = 3'b010,
    cks_undivided = 3'b011,
    cks_code4 = 3'b100
  } amis_cks_t;
endpackage

// ### verilog/amis_chan_map.sv
// maps group, channel pick and mode onto analog input numbers
`include "amis_defs.svh"
module amis_chan_map (
  // configuration
  input wire logic [1:0] group_sel,
  input wire logic channel_pick,
  input wire amis_pkg::amis_opmode_t op_mode,
  // selected inputs
  output logic [2:0] first_input,
  output logic [2:0] second_input,
  output logic [2:0] active_input,
  output logic sweep_en
);
  import amis_pkg::*;
  localparam logic [11:0] first_tbl = `AMIS_GRP_FIRST;
  localparam logic [11:0] second_tbl = `AMIS_GRP_SECOND;
  wire logic [3:0] base = {group_sel, 2'b00} - {2'b00, group_sel};

  // table lookup per group, pick used only in single-channel modes
  assign first_input = first_tbl[base +: 3];
  assign second_input = second_tbl[base +: 3];
  assign sweep_en = (op_mode == op_single_sweep)
    || (op_mode == op_repeat_sweep);
  assign active_input = (!sweep_en && channel_pick)
    ? second_input : first_input;
endmodule

// ### dv/adc_mode_input_select_tb_top.sv
// self-checking bench of the converter mode and input select block
`include "amis_defs.svh"
module adc_mode_input_select_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import amis_pkg::*;
  logic mclk, rst, hsel, hwrite, res_valid, res_second, round_done;
  logic timer_trig, ext_trig_n, hreadyout, hresp, conv_clk_en, sweep_en;
  logic conversion_run_bit;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, first_input, second_input, active_input;
  logic [9:0] res_data;
  amis_opmode_t op_mode;
  amis_trig_t trig_sel;
  int error_cnt, samples_checked, cnt;
  localparam logic [31:0] A_RES0 = 32'(`AMIS_ADDR(`AMIS_IDX_RES0));
  localparam logic [31:0] A_RES1 = 32'(`AMIS_ADDR(`AMIS_IDX_RES1));
  localparam logic [31:0] A_MODE = 32'(`AMIS_ADDR(`AMIS_IDX_MODE));
  localparam logic [31:0] A_INSEL = 32'(`AMIS_ADDR(`AMIS_IDX_INSEL));
  localparam logic [31:0] A_RUN = 32'(`AMIS_ADDR(`AMIS_IDX_RUN));
  localparam logic [31:0] ADDRS [6] = '{A_RES0, A_RES1, A_MODE, A_INSEL,
    A_RUN, 32'h300};
  localparam logic [2:0] FST [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
  localparam logic [2:0] SND [4] = '{3'h1, 3'h3, 3'h7, 3'h6};
  localparam logic [1:0] TRG [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
  localparam int DIVN [5] = '{5, 10, 20, 40, 5};

  // device under test, bus ready looped back
  amis_top amis_top_inst (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .res_valid(res_valid), .res_second(res_second), .res_data(res_data),
    .round_done(round_done), .timer_trig(timer_trig),
    .external_trigger_pin_n(ext_trig_n), .conv_clk_en(conv_clk_en),
    .op_mode(op_mode), .trig_sel(trig_sel), .first_input(first_input),
    .second_input(second_input), .active_input(active_input),
    .sweep_en(sweep_en), .conversion_run_bit(conversion_run_bit)
  );

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // wait for ready; a hang is left to the watchdog
  task automatic wait_rdy;
    do
    begin
      @(posedge mclk);
    end
    while (hreadyout !== 1'b1);
  endtask

  // one ahb-lite single word transfer
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= `AMIS_HSIZE_WORD;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask

  // write and let the outputs follow
  task automatic cfg(input logic [31:0] a, d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge mclk);
  endtask

  // engine event: 0 timer, 1 pin, 2 round done, 3/4 result 0/1
  task automatic ev(input int k);
    @(posedge mclk);
    timer_trig <= (k == 0);
    ext_trig_n <= (k != 1);
    round_done <= (k == 2);
    res_valid <= (k >= 3);
    res_second <= (k == 4);
    res_data <= 10'h2A5 + 10'(k);
    @(posedge mclk);
    timer_trig <= 1'b0;
    ext_trig_n <= 1'b1;
    round_done <= 1'b0;
    res_valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_of_test;
  end

  // test sequence
  initial
  begin
    {rst, hsel, hwrite, res_valid, res_second, round_done} = 6'h20;
    {timer_trig, ext_trig_n, htrans, hsize, res_data} = 17'h08000;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk({op_mode, trig_sel, sweep_en, active_input}, 32'h0);
    chk(conversion_run_bit, 32'h0);
    foreach (ADDRS[i])
    begin
      xfer(1'b0, ADDRS[i], 32'h0);
      chk(rd, 32'h0);
    end
    $display("test reset finished");
    for (int m = 0; m < 4; m++)
    begin
      cfg(A_MODE, 32'({TRG[m], 1'b0, 2'(m), 3'(m)}));
      xfer(1'b0, A_MODE, 32'h0);
      chk(rd, 32'({TRG[m], 1'b0, 2'(m), 3'(m)}));
      chk(op_mode, 32'(m));
      chk(trig_sel, TRG[m]);
    end
    $display("test modes finished");
    for (int c = 0; c < 5; c++)
    begin
      cfg(A_MODE, 32'(c));
      repeat (8) @(posedge mclk);
      cnt = 0;
      repeat (40)
      begin
        @(posedge mclk);
        cnt += conv_clk_en;
      end
      chk(cnt, DIVN[c]);
    end
    $display("test clock finished");
    for (int i = 0; i < 16; i++)
    begin
      cfg(A_MODE, i[1] ? 32'h10 : 32'h00);
      cfg(A_INSEL, 32'({2'(i >> 2), 5'h00, i[0]}));
      chk(first_input, FST[i >> 2]);
      chk(second_input, SND[i >> 2]);
      chk(active_input, (i[1] || !i[0]) ? FST[i >> 2] : SND[i >> 2]);
      chk(sweep_en, i[1]);
    end
    xfer(1'b0, A_INSEL, 32'h0);
    chk(rd, 32'hC1);
    $display("test groups finished");
    cfg(A_MODE, 32'h00);
    ev(0);
    chk(conversion_run_bit, 32'h0);
    cfg(A_MODE, 32'h80);
    ev(1);
    chk(conversion_run_bit, 32'h0);
    ev(0);
    chk(conversion_run_bit, 32'h1);
    ev(2);
    chk(conversion_run_bit, 32'h0);
    cfg(A_MODE, 32'hD0);
    ev(0);
    chk(conversion_run_bit, 32'h0);
    ev(1);
    chk(conversion_run_bit, 32'h1);
    ev(2);
    chk(conversion_run_bit, 32'h0);
    cfg(A_MODE, 32'h08);
    cfg(A_RUN, 32'h1);
    xfer(1'b0, A_RUN, 32'h0);
    chk(rd, 32'h1);
    ev(2);
    chk(conversion_run_bit, 32'h1);
    cfg(A_RUN, 32'h0);
    chk(conversion_run_bit, 32'h0);
    $display("test triggers finished");
    ev(3);
    ev(4);
    xfer(1'b0, A_RES0, 32'h0);
    chk(rd, 32'h2A8);
    xfer(1'b0, A_RES1, 32'h0);
    chk(rd, 32'h2A9);
    $display("test results finished");
    end_of_test;
  end
endmodule
